// *** common/ciu_defines.vh ***
`ifndef CIU_DEFINES_VH
`define CIU_DEFINES_VH

// ==========================================
// register addresses on the special register port
`define CIU_ADDR_POWER_CONTROL 8'h87
`define CIU_ADDR_EXT_IRQ_FLAGS 8'h91
`define CIU_ADDR_BASE_IRQ_ENABLE 8'hA8
`define CIU_ADDR_BASE_IRQ_PRIORITY 8'hB8
`define CIU_ADDR_EXT_IRQ_CONTROL 8'hD8
`define CIU_ADDR_EXTENDED_IRQ_ENABLE 8'hE8
`define CIU_ADDR_EXTENDED_IRQ_PRIORITY 8'hF8

// ==========================================
// reset values and bits that read as constants
`define CIU_RST_BYTE 8'h00
`define CIU_EXT_EN_ONES 8'hE0
`define CIU_BASE_PRI_ONES 8'h80
`define CIU_FLAGS_ONES 8'h08
`define CIU_CONTROL_ONES 8'h40

// ==========================================
// field positions
`define CIU_BIT_GLOBAL_EN 7
`define CIU_BIT_IDLE 0
`define CIU_BIT_FLAG_LO 2
`define CIU_BIT_FLAG_HI 3
`define CIU_BIT_BAUD_DBL 7
`define CIU_BIT_RESUME_FLAG 4
`define CIU_BIT_RESUME_EN 5
`define CIU_BIT_EXT6_FLAG 3
`define CIU_BIT_BAUD_DBL1 7

// ==========================================
// natural priority numbers, lower wins
`define CIU_SRC_RESUME 4'd0
`define CIU_SRC_EXT0 4'd1
`define CIU_SRC_TMR0 4'd2
`define CIU_SRC_EXT1 4'd3
`define CIU_SRC_TMR1 4'd4
`define CIU_SRC_SER0 4'd5
`define CIU_SRC_TMR2 4'd6
`define CIU_SRC_SER1 4'd7
`define CIU_SRC_USB 4'd8
`define CIU_SRC_I2C 4'd9
`define CIU_SRC_EXT4 4'd10
`define CIU_SRC_EXT5 4'd11
`define CIU_SRC_EXT6 4'd12
`define CIU_NUM_SRC 13

// ==========================================
// service levels
`define CIU_LVL_LOW 2'd0
`define CIU_LVL_HIGH 2'd1
`define CIU_LVL_TOP 2'd2

// ==========================================
// vectors
`define CIU_VEC_RESUME 8'h33
`define CIU_VEC_EXT0 8'h03
`define CIU_VEC_TMR0 8'h0B
`define CIU_VEC_EXT1 8'h13
`define CIU_VEC_TMR1 8'h1B
`define CIU_VEC_SER0 8'h23
`define CIU_VEC_TMR2 8'h2B
`define CIU_VEC_SER1 8'h3B
`define CIU_VEC_USB 8'h43
`define CIU_VEC_I2C 8'h4B
`define CIU_VEC_EXT4 8'h53
`define CIU_VEC_EXT5 8'h5B
`define CIU_VEC_EXT6 8'h63

// ==========================================
// timing in instruction cycles
`define CIU_DETECT_CYCLES 1
`define CIU_CALL_CYCLES 4

`endif

// *** core/ciu_edge_sample.v ***
`timescale 1ns/1ps
`default_nettype none

module ciu_edge_sample #(
    parameter W = 7
) (
    // clock and reset
    input wire core_clk,
    input wire reset,
    // sampling
    input wire sample_stb,
    input wire [W-1:0] din,
    // results
    output wire [W-1:0] level_r,
    output wire [W-1:0] rise,
    output wire [W-1:0] fall
);

    reg new_r;

    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
            new_r <= 1'b0;
        else
            new_r <= sample_stb;
    end

    // ==========================================
    // one sample per instruction cycle, compared with the one before
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            reg cur_r;
            reg prev_r;
            always @(posedge core_clk or posedge reset)
            begin
                if (reset)
                begin
                    cur_r <= 1'b1;
                    prev_r <= 1'b1;
                end
                else if (sample_stb)
                begin
                    prev_r <= cur_r;
                    cur_r <= din[i];
                end
            end
            assign level_r[i] = cur_r;
            assign rise[i] = new_r & cur_r & ~prev_r;
            assign fall[i] = new_r & ~cur_r & prev_r;
        end
    endgenerate

endmodule

`default_nettype wire

// *** core/ciu_pick.v ***
`timescale 1ns/1ps
`default_nettype none

`include "ciu_defines.vh"

module ciu_pick #(
    parameter N = 13
) (
    // requests
    input wire [N-1:0] pend,
    input wire [N-1:0] high_sel,
    // winner
    output reg win_valid,
    output reg [3:0] win_idx,
    output reg [1:0] win_lvl
);

    integer k;
    reg found_hi;
    reg found_lo;
    reg [3:0] idx_hi;
    reg [3:0] idx_lo;

    // ==========================================
    // level first, then natural order
    always @*
    begin
        found_hi = 1'b0;
        found_lo = 1'b0;
        idx_hi = 4'h0;
        idx_lo = 4'h0;
        for (k = N - 1; k >= 1; k = k - 1)
        begin
            if (pend[k] && high_sel[k])
            begin
                found_hi = 1'b1;
                idx_hi = k[3:0];
            end
            if (pend[k] && !high_sel[k])
            begin
                found_lo = 1'b1;
                idx_lo = k[3:0];
            end
        end
        win_valid = 1'b1;
        if (pend[0])
        begin
            win_idx = 4'h0;
            win_lvl = `CIU_LVL_TOP;
        end
        else if (found_hi)
        begin
            win_idx = idx_hi;
            win_lvl = `CIU_LVL_HIGH;
        end
        else
        begin
            win_valid = found_lo;
            win_idx = idx_lo;
            win_lvl = `CIU_LVL_LOW;
        end
    end

endmodule

`default_nettype wire

// *** core/ciu_top.v ***
`timescale 1ns/1ps
`default_nettype none

`include "ciu_defines.vh"

//
// Contract
// R1: extended enable bits 4..0: ext6, ext5, ext4, i2c, usb; bits 7..5 read one
// R2: extended priority bits 4..0 same order; one means high, zero low
// R3: an accepted request branches to the fixed vector of its source
// R4: return resumes at the instruction that would have followed
// R5: low routine preempted by high or resume; high only by resume
// R6: finish current instruction; after return or enable/priority write, one more
// R7: global enable masks all but resume; when set, own enables apply
// R8: same-level ties resolved by natural order, lower number wins
// R9: level beats natural order; resume alone is highest level
// R10: each source maps to its own flag, enable and priority bits
// R11: timers and serial ports raise flags; pins sampled each instruction cycle
// R12: ext 0/1 active low; type clear is level, type set is falling edge
// R13: ext 4-6, usb and i2c edge only; 4 and 6 rising, 5 falling
// R14: edge inputs held high four clocks, then low four clocks
// R15: level requests must stay asserted until serviced
// R16: fastest response five cycles: one detect, four for the call
// R17: slowest thirteen cycles when a return precedes multiply or divide
// R18: after return at least one program instruction runs before reentry
// R19: setting idle bit enters idle when that instruction completes
// R20: while idle, request chip suspend and oscillator stop
// R21: power control: baud doubler 7, flags 3 and 2, idle 0, bit 1 zero
// R22: edge flags stay until cleared by software; software set raises request
// R23: pending needs flag, own enable and global enable; resume ignores global
module ciu_top (
    // clock and reset
    input wire core_clk,
    input wire reset,
    // special register port
    input wire [7:0] sfr_addr,
    input wire sfr_wr_en,
    input wire [7:0] sfr_wdata,
    input wire sfr_rd_en,
    output reg [7:0] sfr_rdata,
    // cpu sequencer
    input wire instr_cycle_stb,
    input wire instr_done,
    input wire instr_is_return,
    output reg vec_take,
    output reg [7:0] vec_addr,
    output wire [2:0] in_service,
    // external pins and peripheral requests
    input wire ext_irq_zero_n,
    input wire ext_irq_one_n,
    input wire ext_irq_four,
    input wire ext_irq_five_n,
    input wire ext_irq_six,
    input wire bus_irq_line,
    input wire twowire_irq_line,
    input wire resume_event,
    input wire ext_zero_type,
    input wire ext_one_type,
    input wire timer_zero_overflow,
    input wire timer_one_overflow,
    input wire timer_two_overflow,
    input wire timer_two_external_flag,
    input wire serial_zero_tx_flag,
    input wire serial_zero_rx_flag,
    input wire serial_one_tx_flag,
    input wire serial_one_rx_flag,
    // status toward the rest of the chip
    output wire ext_zero_pending,
    output wire ext_one_pending,
    output wire serial_zero_baud_doubler,
    output wire serial_one_baud_doubler,
    output wire idle_mode,
    output wire chip_suspend_req,
    output wire osc_stop_req
);

    // ==========================================
    // registers
    reg [7:0] base_en_r;
    reg [7:0] base_pri_r;
    reg [4:0] ext_en_r;
    reg [4:0] ext_pri_r;
    reg [3:0] ext_flags_r;
    reg ctl_baud1_r;
    reg ctl_resume_en_r;
    reg ctl_resume_flag_r;
    reg ctl_ext6_flag_r;
    reg pwr_baud_r;
    reg [1:0] pwr_gf_r;
    reg idle_req_r;
    reg idle_r;
    reg ext0_edge_r;
    reg ext1_edge_r;
    reg [2:0] active_r;
    reg guard_wr_r;

    wire wr_pwr = sfr_wr_en && (sfr_addr == `CIU_ADDR_POWER_CONTROL);
    wire wr_flags = sfr_wr_en && (sfr_addr == `CIU_ADDR_EXT_IRQ_FLAGS);
    wire wr_ben = sfr_wr_en && (sfr_addr == `CIU_ADDR_BASE_IRQ_ENABLE);
    wire wr_bpri = sfr_wr_en && (sfr_addr == `CIU_ADDR_BASE_IRQ_PRIORITY);
    wire wr_ctl = sfr_wr_en && (sfr_addr == `CIU_ADDR_EXT_IRQ_CONTROL);
    wire wr_xen = sfr_wr_en && (sfr_addr == `CIU_ADDR_EXTENDED_IRQ_ENABLE);
    wire wr_xpri = sfr_wr_en && (sfr_addr == `CIU_ADDR_EXTENDED_IRQ_PRIORITY);

    // ==========================================
    // pin sampling, once per instruction cycle
    wire [6:0] smp_level;
    wire [6:0] smp_rise;
    wire [6:0] smp_fall;

    // pulses shorter than four clocks high and low may be missed R14
    ciu_edge_sample #(
        .W(7)
    ) u_sample (
        .core_clk(core_clk),
        .reset(reset),
        .sample_stb(instr_cycle_stb), // R11
        .din({twowire_irq_line, bus_irq_line, ext_irq_six, ext_irq_five_n,
            ext_irq_four, ext_irq_one_n, ext_irq_zero_n}),
        .level_r(smp_level),
        .rise(smp_rise),
        .fall(smp_fall)
    );

    wire set_ext4 = smp_rise[2]; // R13
    wire set_ext5 = smp_fall[3]; // R13
    wire set_ext6 = smp_rise[4]; // R13
    wire set_usb = smp_rise[5]; // R13
    wire set_i2c = smp_rise[6]; // R13

    // ==========================================
    // external 0 and 1: level mode follows the pin, edge mode latches
    // a level request is not held here, the source keeps it up R15
    assign ext_zero_pending = ext_zero_type ? ext0_edge_r : ~smp_level[0]; // R12
    assign ext_one_pending = ext_one_type ? ext1_edge_r : ~smp_level[1]; // R12

    // ==========================================
    // flags, enables and priorities per source
    wire [12:0] flag_vec;
    wire [12:0] en_vec;
    wire [12:0] hi_vec;
    wire [12:0] pend_vec;

    // R10
    assign flag_vec = {ctl_ext6_flag_r, ext_flags_r[3], ext_flags_r[2],
        ext_flags_r[1], ext_flags_r[0],
        serial_one_tx_flag | serial_one_rx_flag,
        timer_two_overflow | timer_two_external_flag,
        serial_zero_tx_flag | serial_zero_rx_flag,
        timer_one_overflow, ext_one_pending, timer_zero_overflow,
        ext_zero_pending, ctl_resume_flag_r}; // R11
    // R10
    assign en_vec = {ext_en_r, base_en_r[6:0], ctl_resume_en_r};
    assign hi_vec = {ext_pri_r, base_pri_r[6:0], 1'b1};

    wire global_en = base_en_r[`CIU_BIT_GLOBAL_EN];

    // R7 R23
    assign pend_vec = flag_vec & en_vec & {{12{global_en}}, 1'b1};

    wire win_valid;
    wire [3:0] win_idx;
    wire [1:0] win_lvl;

    // R8 R9
    ciu_pick #(
        .N(`CIU_NUM_SRC)
    ) u_pick (
        .pend(pend_vec),
        .high_sel(hi_vec),
        .win_valid(win_valid),
        .win_idx(win_idx),
        .win_lvl(win_lvl)
    );

    // ==========================================
    // preemption against the level now in service
    reg preempt_ok;

    always @*
    begin
        if (active_r[2])
            preempt_ok = 1'b0;
        else if (active_r[1])
            preempt_ok = (win_lvl == `CIU_LVL_TOP); // R5
        else if (active_r[0])
            preempt_ok = (win_lvl != `CIU_LVL_LOW); // R5
        else
            preempt_ok = 1'b1;
    end

    // decision point: end of an instruction, or each instruction cycle strobe while idle
    wire boundary = instr_done | (idle_r & instr_cycle_stb); // R6 R16
    // a return or control write gets one more instruction before any vectoring
    wire ctl_wr = wr_ben | wr_bpri | wr_xen | wr_xpri;
    wire hold_off = instr_done & (instr_is_return | guard_wr_r | ctl_wr); // R6 R18
    wire take = boundary && win_valid && preempt_ok && !hold_off; // R6 R18
    wire ret_done = instr_done & instr_is_return; // R4

    // ==========================================
    // vector lookup
    reg [7:0] vec_nxt;

    always @*
    begin
        case (win_idx) // R3
            `CIU_SRC_RESUME: vec_nxt = `CIU_VEC_RESUME;
            `CIU_SRC_EXT0: vec_nxt = `CIU_VEC_EXT0;
            `CIU_SRC_TMR0: vec_nxt = `CIU_VEC_TMR0;
            `CIU_SRC_EXT1: vec_nxt = `CIU_VEC_EXT1;
            `CIU_SRC_TMR1: vec_nxt = `CIU_VEC_TMR1;
            `CIU_SRC_SER0: vec_nxt = `CIU_VEC_SER0;
            `CIU_SRC_TMR2: vec_nxt = `CIU_VEC_TMR2;
            `CIU_SRC_SER1: vec_nxt = `CIU_VEC_SER1;
            `CIU_SRC_USB: vec_nxt = `CIU_VEC_USB;
            `CIU_SRC_I2C: vec_nxt = `CIU_VEC_I2C;
            `CIU_SRC_EXT4: vec_nxt = `CIU_VEC_EXT4;
            `CIU_SRC_EXT5: vec_nxt = `CIU_VEC_EXT5;
            `CIU_SRC_EXT6: vec_nxt = `CIU_VEC_EXT6;
            default: vec_nxt = `CIU_VEC_RESUME;
        endcase
    end

    // ==========================================
    // vector handoff; the sequencer runs the four-cycle long call R16 R17
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            vec_take <= 1'b0;
            vec_addr <= `CIU_RST_BYTE;
        end
        else
        begin
            vec_take <= take;
            if (take)
                vec_addr <= vec_nxt; // R3
        end
    end

    // ==========================================
    // in-service levels, a return retires the highest one
    assign in_service = active_r;

    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
            active_r <= 3'b000;
        else if (take)
            active_r <= active_r | (3'b001 << win_lvl); // R5
        else if (ret_done)
        begin
            if (active_r[2])
                active_r[2] <= 1'b0; // R4
            else if (active_r[1])
                active_r[1] <= 1'b0; // R4
            else
                active_r[0] <= 1'b0; // R4
        end
    end

    // ==========================================
    // control write seen earlier in the current instruction
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
            guard_wr_r <= 1'b0;
        else if (instr_done)
            guard_wr_r <= 1'b0;
        else if (ctl_wr)
            guard_wr_r <= 1'b1; // R6
    end

    // ==========================================
    // edge latches for external 0 and 1, cleared when vectored
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            ext0_edge_r <= 1'b0;
            ext1_edge_r <= 1'b0;
        end
        else
        begin
            if (ext_zero_type && smp_fall[0])
                ext0_edge_r <= 1'b1; // R12
            else if (take && win_idx == `CIU_SRC_EXT0)
                ext0_edge_r <= 1'b0;
            if (ext_one_type && smp_fall[1])
                ext1_edge_r <= 1'b1; // R12
            else if (take && win_idx == `CIU_SRC_EXT1)
                ext1_edge_r <= 1'b0;
        end
    end

    // ==========================================
    // sticky flags: hardware set wins over a software clear
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            ext_flags_r <= 4'h0;
            ctl_resume_flag_r <= 1'b0;
            ctl_ext6_flag_r <= 1'b0;
        end
        else
        begin
            // bits: 0 usb, 1 i2c, 2 ext4, 3 ext5
            ext_flags_r <= (wr_flags ? sfr_wdata[7:4] : ext_flags_r)
                | {set_ext5, set_ext4, set_i2c, set_usb}; // R22
            ctl_resume_flag_r <= (wr_ctl ? sfr_wdata[`CIU_BIT_RESUME_FLAG]
                : ctl_resume_flag_r) | resume_event; // R22
            ctl_ext6_flag_r <= (wr_ctl ? sfr_wdata[`CIU_BIT_EXT6_FLAG]
                : ctl_ext6_flag_r) | set_ext6; // R22
        end
    end

    // ==========================================
    // enable, priority and control registers
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            base_en_r <= `CIU_RST_BYTE;
            base_pri_r <= `CIU_RST_BYTE;
            ext_en_r <= 5'h00;
            ext_pri_r <= 5'h00;
            ctl_baud1_r <= 1'b0;
            ctl_resume_en_r <= 1'b0;
        end
        else
        begin
            if (wr_ben)
                base_en_r <= sfr_wdata; // R7
            if (wr_bpri)
                base_pri_r <= {1'b0, sfr_wdata[6:0]};
            if (wr_xen)
                ext_en_r <= sfr_wdata[4:0]; // R1
            if (wr_xpri)
                ext_pri_r <= sfr_wdata[4:0]; // R2
            if (wr_ctl)
            begin
                ctl_baud1_r <= sfr_wdata[`CIU_BIT_BAUD_DBL1];
                ctl_resume_en_r <= sfr_wdata[`CIU_BIT_RESUME_EN];
            end
        end
    end

    // ==========================================
    // power control and idle
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            pwr_baud_r <= 1'b0;
            pwr_gf_r <= 2'b00;
            idle_req_r <= 1'b0;
            idle_r <= 1'b0;
        end
        else
        begin
            if (wr_pwr)
            begin
                pwr_baud_r <= sfr_wdata[`CIU_BIT_BAUD_DBL]; // R21
                pwr_gf_r <= sfr_wdata[`CIU_BIT_FLAG_HI:`CIU_BIT_FLAG_LO]; // R21
            end
            if (take)
            begin
                idle_req_r <= 1'b0;
                idle_r <= 1'b0;
            end
            else
            begin
                if (wr_pwr)
                    idle_req_r <= sfr_wdata[`CIU_BIT_IDLE]; // R19
                if (instr_done && (idle_req_r || (wr_pwr && sfr_wdata[`CIU_BIT_IDLE])))
                    idle_r <= 1'b1; // R19
            end
        end
    end

    assign idle_mode = idle_r; // R19
    assign chip_suspend_req = idle_r; // R20
    assign osc_stop_req = idle_r; // R20
    assign serial_zero_baud_doubler = pwr_baud_r;
    assign serial_one_baud_doubler = ctl_baud1_r;

    // ==========================================
    // register read, one cycle after the strobe
    reg [7:0] rd_nxt;

    always @*
    begin
        case (sfr_addr)
            `CIU_ADDR_POWER_CONTROL:
                rd_nxt = {pwr_baud_r, 3'b000, pwr_gf_r, 1'b0, idle_req_r}; // R21
            `CIU_ADDR_EXT_IRQ_FLAGS:
                rd_nxt = {ext_flags_r, 4'h0} | `CIU_FLAGS_ONES;
            `CIU_ADDR_BASE_IRQ_ENABLE:
                rd_nxt = base_en_r;
            `CIU_ADDR_BASE_IRQ_PRIORITY:
                rd_nxt = base_pri_r | `CIU_BASE_PRI_ONES;
            `CIU_ADDR_EXT_IRQ_CONTROL:
                rd_nxt = {ctl_baud1_r, 1'b0, ctl_resume_en_r, ctl_resume_flag_r,
                    ctl_ext6_flag_r, 3'b000} | `CIU_CONTROL_ONES;
            `CIU_ADDR_EXTENDED_IRQ_ENABLE:
                rd_nxt = {3'b000, ext_en_r} | `CIU_EXT_EN_ONES; // R1
            `CIU_ADDR_EXTENDED_IRQ_PRIORITY:
                rd_nxt = {3'b000, ext_pri_r} | `CIU_EXT_EN_ONES; // R2
            default:
                rd_nxt = `CIU_RST_BYTE;
        endcase
    end

    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
            sfr_rdata <= `CIU_RST_BYTE;
        else if (sfr_rd_en)
            sfr_rdata <= rd_nxt;
    end

endmodule

`default_nettype wire

// *** verification/ciu_top_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========
// checker
module ciu_top_asserts (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_rd_en,
    input wire logic [7:0] sfr_rdata,
    // sequencer
    input wire logic instr_cycle_stb,
    input wire logic instr_done,
    input wire logic instr_is_return,
    input wire logic vec_take,
    input wire logic [7:0] vec_addr,
    input wire logic [2:0] in_service,
    // power
    input wire logic idle_mode,
    input wire logic chip_suspend_req,
    input wire logic osc_stop_req
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    AST_EN_ONES:
    assert property (sfr_rd_en && sfr_addr == 8'hE8 |=> sfr_rdata[7:5] == 3'b111)
        else $error("enable upper bits");
    AST_PRI_ONES:
    assert property (sfr_rd_en && sfr_addr == 8'hF8 |=> sfr_rdata[7:5] == 3'b111)
        else $error("priority upper bits");
    AST_PWR_BIT1:
    assert property (sfr_rd_en && sfr_addr == 8'h87 |=> !sfr_rdata[1])
        else $error("power bit one set");
    AST_AT_BOUNDARY:
    assert property (vec_take |-> $past(instr_done) || $past(instr_cycle_stb && idle_mode))
        else $error("take off boundary");
    AST_NO_REENTRY:
    assert property (instr_done && instr_is_return |=> !vec_take [*4])
        else $error("take right after return");
    AST_PREEMPT:
    assert property (vec_take && $past(in_service[1]) |-> vec_addr == 8'h33)
        else $error("high routine preempted");
    AST_TOP_LEVEL:
    assert property (vec_take && vec_addr == 8'h33 |-> in_service[2])
        else $error("resume not top level");
    AST_IDLE_OUT:
    assert property (chip_suspend_req == idle_mode && osc_stop_req == idle_mode)
        else $error("suspend not tied to idle");
    cover property (vec_take && vec_addr == 8'h33);
    cover property (instr_done && instr_is_return);
    cover property (vec_take && $past(idle_mode));
endmodule

bind ciu_top ciu_top_asserts ciu_top_asserts_inst (.*);
`default_nettype wire

// *** verification/ciu_seq_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========
// sequencer: one instruction per four clocks
module ciu_seq_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // bench request and unit idle status
    input wire logic ret_req,
    input wire logic idle_mode,
    // toward the unit
    output var logic instr_cycle_stb,
    output var logic instr_done,
    output var logic instr_is_return
);
    logic [1:0] cnt_r;
    always @(negedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            cnt_r <= 2'h0;
            instr_cycle_stb <= 1'b0;
            instr_done <= 1'b0;
            instr_is_return <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_r + 2'h1;
            instr_cycle_stb <= (cnt_r == 2'h3);
            instr_done <= (cnt_r == 2'h3) && !idle_mode;
            instr_is_return <= (cnt_r == 2'h3) && !idle_mode && ret_req;
        end
    end
endmodule
`default_nettype wire

// *** verification/test_cpu_interrupt_unit_idle.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module test_cpu_interrupt_unit_idle;
    // ========
    // signals
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr_en = 1'b0;
    logic sfr_rd_en = 1'b0;
    logic ret_req = 1'b0;
    logic [12:0] drv = 13'h0000;
    wire [12:0] pin = drv ^ 13'h080A;
    wire [7:0] sfr_rdata;
    wire [7:0] vec_addr;
    wire [2:0] in_service;
    wire vec_take, instr_cycle_stb, instr_done, instr_is_return;
    wire idle_mode, chip_suspend_req, osc_stop_req, baud0;
    int err_total = 0;
    int n_compared = 0;
    int n_take = 0;
    int t0;
    logic [7:0] last_vec;
    logic [7:0] vt [0:12] = '{8'h33, 8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h3B,
        8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63};
    initial forever #2 core_clk = ~core_clk;
    ciu_top ciu_top_inst (
        .core_clk(core_clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
        .sfr_wdata(sfr_wdata), .sfr_rd_en(sfr_rd_en), .sfr_rdata(sfr_rdata),
        .instr_cycle_stb(instr_cycle_stb), .instr_done(instr_done),
        .instr_is_return(instr_is_return), .vec_take(vec_take), .vec_addr(vec_addr),
        .in_service(in_service), .resume_event(pin[0]), .ext_irq_zero_n(pin[1]),
        .timer_zero_overflow(pin[2]), .ext_irq_one_n(pin[3]), .timer_one_overflow(pin[4]),
        .serial_zero_rx_flag(pin[5]), .serial_zero_tx_flag(pin[5]),
        .timer_two_overflow(pin[6]), .timer_two_external_flag(pin[6]),
        .serial_one_tx_flag(pin[7]), .serial_one_rx_flag(pin[7]), .bus_irq_line(pin[8]),
        .twowire_irq_line(pin[9]), .ext_irq_four(pin[10]), .ext_irq_five_n(pin[11]),
        .ext_irq_six(pin[12]), .ext_zero_type(1'b1), .ext_one_type(1'b0),
        .ext_zero_pending(), .ext_one_pending(), .serial_zero_baud_doubler(baud0),
        .serial_one_baud_doubler(), .idle_mode(idle_mode),
        .chip_suspend_req(chip_suspend_req), .osc_stop_req(osc_stop_req)
    );
    ciu_seq_model ciu_seq_model_inst (.*);
    always @(negedge core_clk)
    begin
        if (vec_take === 1'b1)
        begin
            n_take++;
            last_vec = vec_addr;
        end
    end
    // ========
    // tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr_en <= 1'b1;
        @(negedge core_clk);
        sfr_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        sfr_addr <= a;
        sfr_rd_en <= 1'b1;
        @(negedge core_clk);
        sfr_rd_en <= 1'b0;
        `CHK(sfr_rdata, e)
    endtask
    task automatic take(input int c, input logic [7:0] e);
        for (int k = 0; k < 80 && n_take == c; k++)
            @(negedge core_clk);
        `CHK(n_take, c + 1)
        `CHK(last_vec, e)
    endtask
    task automatic quiet(input int n);
        int c;
        c = n_take;
        repeat (n) @(negedge core_clk);
        `CHK(n_take, c)
    endtask
    task automatic ret();
        @(negedge core_clk);
        ret_req <= 1'b1;
        repeat (4) @(negedge core_clk);
        ret_req <= 1'b0;
    endtask
    // edge inputs held active eight clocks, resume one clock, levels until taken
    task automatic fire(input int i);
        int c;
        c = n_take;
        @(negedge core_clk);
        drv[i] <= 1'b1;
        repeat ((i == 0) ? 1 : 8) @(negedge core_clk);
        if (!(i inside {[2:7]}))
            drv[i] <= 1'b0;
        take(c, vt[i]);
        drv[i] <= 1'b0;
        wr(8'h91, 8'h00);
        wr(8'hD8, 8'h20);
        ret();
    endtask
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ========
    // tests
    initial
    begin
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        reset <= 1'b0;
        rd(8'hE8, 8'hE0);
        rd(8'hF8, 8'hE0);
        rd(8'h87, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'hE8, 8'h1F);
        rd(8'hE8, 8'hFF);
        wr(8'hF8, 8'h15);
        rd(8'hF8, 8'hF5);
        wr(8'h87, 8'h8C);
        rd(8'h87, 8'h8C);
        `CHK(baud0, 1'b1)
        wr(8'hF8, 8'h00);
        wr(8'hA8, 8'hFF);
        wr(8'hD8, 8'h20);
        for (int i = 0; i < 13; i++)
            fire(i);
        t0 = n_take;
        wr(8'h91, 8'h50);
        take(t0, 8'h43);
        wr(8'h91, 8'h40);
        quiet(24);
        ret();
        take(t0 + 1, 8'h53);
        wr(8'h91, 8'h00);
        ret();
        wr(8'hF8, 8'h02);
        t0 = n_take;
        wr(8'h91, 8'h30);
        take(t0, 8'h4B);
        wr(8'h91, 8'h10);
        wr(8'hD8, 8'h30);
        take(t0 + 1, 8'h33);
        wr(8'hD8, 8'h20);
        ret();
        ret();
        take(t0 + 2, 8'h43);
        wr(8'h91, 8'h00);
        ret();
        wr(8'hA8, 8'h00);
        wr(8'h91, 8'h10);
        quiet(24);
        t0 = n_take;
        wr(8'hD8, 8'h30);
        take(t0, 8'h33);
        wr(8'hD8, 8'h20);
        ret();
        wr(8'h91, 8'h00);
        wr(8'hA8, 8'hFF);
        wr(8'h87, 8'h01);
        repeat (4) @(negedge core_clk);
        `CHK({idle_mode, chip_suspend_req, osc_stop_req}, 3'b111)
        fire(10);
        `CHK(idle_mode, 1'b0)
        tally_and_finish();
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
